// file: core/trc_defines.svh
// constants of the tiny risc core datapath
`ifndef TRC_DEFINES_SVH
`define TRC_DEFINES_SVH

// ----------------------------------------------------------------------
// variant and width constants
// ----------------------------------------------------------------------
`define TRC_PROG_DEPTH 512
`define TRC_DATA_BYTES 24
`define TRC_IW         12
`define TRC_DW         8
`define TRC_FA_W       5
`define TRC_PCX_W      10
`define TRC_FILE_SPAN  32

// ----------------------------------------------------------------------
// register file map
// ----------------------------------------------------------------------
`define TRC_ADR_INDF   5'h00
`define TRC_ADR_TMR    5'h01
`define TRC_ADR_PCL    5'h02
`define TRC_ADR_STATUS 5'h03
`define TRC_ADR_FSR    5'h04
`define TRC_ADR_EXT_LO 5'h05
`define TRC_ADR_EXT_HI 5'h07

// ----------------------------------------------------------------------
// status and pointer layout, reset values
// ----------------------------------------------------------------------
`define TRC_ST_C       0
`define TRC_ST_DC      1
`define TRC_ST_Z       2
`define TRC_ST_RESET   8'h18
`define TRC_ST_WMASK   8'hc7
`define TRC_FSR_HI     8'he0
`define TRC_BYTE_ZERO  8'h00

// ----------------------------------------------------------------------
// instruction fields
// ----------------------------------------------------------------------
`define TRC_F_ADDR     4:0
`define TRC_F_DEST     5
`define TRC_F_BIT      7:5
`define TRC_F_K8       7:0
`define TRC_F_K9       8:0
`define TRC_F_CTRL     2:0

// ----------------------------------------------------------------------
// opcode patterns
// ----------------------------------------------------------------------
`define TRC_OP_NOP     12'b0000_0000_0000
`define TRC_OP_CTRL    12'b0000_0000_0???
`define TRC_OP_MOVWF   12'b0000_001?_????
`define TRC_OP_CLRW    12'b0000_0100_0000
`define TRC_OP_CLRF    12'b0000_011?_????
`define TRC_OP_SUBWF   12'b0000_10??_????
`define TRC_OP_DECF    12'b0000_11??_????
`define TRC_OP_IORWF   12'b0001_00??_????
`define TRC_OP_ANDWF   12'b0001_01??_????
`define TRC_OP_XORWF   12'b0001_10??_????
`define TRC_OP_ADDWF   12'b0001_11??_????
`define TRC_OP_MOVF    12'b0010_00??_????
`define TRC_OP_COMF    12'b0010_01??_????
`define TRC_OP_INCF    12'b0010_10??_????
`define TRC_OP_DECFSZ  12'b0010_11??_????
`define TRC_OP_RRF     12'b0011_00??_????
`define TRC_OP_RLF     12'b0011_01??_????
`define TRC_OP_SWAPF   12'b0011_10??_????
`define TRC_OP_INCFSZ  12'b0011_11??_????
`define TRC_OP_BCF     12'b0100_????_????
`define TRC_OP_BSF     12'b0101_????_????
`define TRC_OP_BTFSC   12'b0110_????_????
`define TRC_OP_BTFSS   12'b0111_????_????
`define TRC_OP_RETLW   12'b1000_????_????
`define TRC_OP_CALL    12'b1001_????_????
`define TRC_OP_GOTO    12'b101?_????_????
`define TRC_OP_MOVLW   12'b1100_????_????
`define TRC_OP_IORLW   12'b1101_????_????
`define TRC_OP_ANDLW   12'b1110_????_????
`define TRC_OP_XORLW   12'b1111_????_????

`endif

// file: core/trc_pkg.sv
// types shared by the tiny risc core datapath
`include "trc_defines.svh"
package trc_pkg;
  typedef logic [`TRC_IW-1:0]   trc_word_t;
  typedef logic [`TRC_DW-1:0]   trc_byte_t;
  typedef logic [`TRC_FA_W-1:0] trc_fadr_t;
  typedef enum logic [3:0] {
    TRC_Q1 = 4'h1,
    TRC_Q2 = 4'h2,
    TRC_Q3 = 4'h4,
    TRC_Q4 = 4'h8
  } trc_phase_e;
endpackage

// file: core/trc_ram_if.sv
// port bundle between the core and its general purpose byte store
`timescale 1ns/1ps
`include "trc_defines.svh"
interface trc_ram_if #(parameter int AW = 5);
  logic                we;
  logic                re;
  logic [AW-1:0]       addr;
  logic [`TRC_DW-1:0]  wdata;
  logic [`TRC_DW-1:0]  rdata;
  modport core (output we, output re, output addr, output wdata, input rdata);
  modport mem  (input we, input re, input addr, input wdata, output rdata);
endinterface

// file: core/trc_gpr_ram.sv
// general purpose byte store with registered read data
`timescale 1ns/1ps
`include "trc_defines.svh"
module trc_gpr_ram #(
  parameter int DEPTH = `TRC_DATA_BYTES
) (
  input wire logic clk,
  input wire logic arst_n,
  trc_ram_if.mem   bus
);
  logic [`TRC_DW-1:0] mem [DEPTH];
  logic [`TRC_DW-1:0] rdata_ff;

  always_ff @(posedge clk) begin
    if (bus.we) begin
      mem[bus.addr] <= bus.wdata;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_ff <= `TRC_BYTE_ZERO;
    end else if (bus.re) begin
      rdata_ff <= mem[bus.addr];
    end
  end

  assign bus.rdata = rdata_ff;
endmodule // trc_gpr_ram

// file: core/trc_core.sv
// two-stage fetch/execute datapath of the tiny risc core
`timescale 1ns/1ps
`include "trc_defines.svh"

module trc_core #(
  parameter int  PROG_DEPTH = `TRC_PROG_DEPTH,
  parameter int  DATA_BYTES = `TRC_DATA_BYTES,
  localparam int PC_W       = $clog2(PROG_DEPTH)
) (
  input  wire logic              clk,
  input  wire logic              arst_n,
  output logic [PC_W-1:0]        progAddr,
  input  wire trc_pkg::trc_word_t progData,
  output trc_pkg::trc_fadr_t     periphAddr,
  output logic                   periphRe,
  input  wire trc_pkg::trc_byte_t periphRdData,
  output logic                   periphWe,
  output trc_pkg::trc_byte_t     periphWrData,
  output logic                   ctrlStrobe,
  output logic [2:0]             ctrlCode,
  output trc_pkg::trc_byte_t     ctrlData
);
  import trc_pkg::*;

  localparam int        RA_W     = $clog2(DATA_BYTES);
  localparam trc_fadr_t GPR_BASE = trc_fadr_t'(`TRC_FILE_SPAN - DATA_BYTES);

  trc_phase_e          phase_ff;
  trc_phase_e          nxt_phase;
  trc_word_t           ir_ff;
  logic                exeValid_ff;
  logic [PC_W-1:0]     pc_ff;
  logic [PC_W-1:0]     progAddr_ff;
  logic [PC_W-1:0]     stk0_ff;
  logic [PC_W-1:0]     stk1_ff;
  trc_byte_t           w_ff;
  trc_byte_t           status_ff;
  trc_byte_t           nxt_status;
  trc_byte_t           fsr_ff;
  trc_byte_t           extRd_ff;
  trc_fadr_t           periphAddr_ff;
  logic                periphRe_ff;
  logic                periphWe_ff;
  trc_byte_t           periphWrData_ff;
  logic                ctrlStrobe_ff;
  logic [2:0]          ctrlCode_ff;
  trc_byte_t           ctrlData_ff;

  trc_fadr_t           eff;
  logic                isGpr;
  logic                isExt;
  trc_byte_t           fileVal;
  logic [`TRC_PCX_W-1:0] pcx;
  trc_byte_t           kLit;
  trc_byte_t           bitMask;
  logic [8:0]          addRes;
  logic [8:0]          subRes;
  logic [4:0]          addNib;
  logic [4:0]          subNib;
  trc_byte_t           res;
  logic                toW;
  logic                toF;
  logic                cAff;
  logic                dcAff;
  logic                zAff;
  logic                cNew;
  logic                dcNew;
  logic                skip;
  logic                flow;
  logic                push;
  logic                pop;
  logic                ctrlOp;
  logic [`TRC_PCX_W-1:0] tgt;
  logic                exe;
  logic                atQ4;

  trc_ram_if #(.AW(RA_W)) ramBus ();

  // ----------------------------------------------------------------------
  // phase generator
  // ----------------------------------------------------------------------
  always_comb begin
    case (phase_ff)
      TRC_Q1:  nxt_phase = TRC_Q2;
      TRC_Q2:  nxt_phase = TRC_Q3;
      TRC_Q3:  nxt_phase = TRC_Q4;
      TRC_Q4:  nxt_phase = TRC_Q1;
      default: nxt_phase = TRC_Q1;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      phase_ff <= TRC_Q1;
    end else begin
      phase_ff <= nxt_phase;
    end
  end

  assign atQ4 = (phase_ff == TRC_Q4);
  assign exe  = exeValid_ff;

  // ----------------------------------------------------------------------
  // operand addressing
  // ----------------------------------------------------------------------
  always_comb begin
    eff = (ir_ff[`TRC_F_ADDR] == `TRC_ADR_INDF) ? fsr_ff[`TRC_F_ADDR]
                                                  : ir_ff[`TRC_F_ADDR];
    isGpr = (eff >= GPR_BASE);
    isExt = (eff == `TRC_ADR_TMR) || ((eff >= `TRC_ADR_EXT_LO) && (eff <= `TRC_ADR_EXT_HI));
    pcx   = `TRC_PCX_W'(progAddr_ff);
    case (eff)
      `TRC_ADR_INDF:   fileVal = `TRC_BYTE_ZERO;
      `TRC_ADR_PCL:    fileVal = pcx[`TRC_F_K8];
      `TRC_ADR_STATUS: fileVal = status_ff;
      `TRC_ADR_FSR:    fileVal = fsr_ff | `TRC_FSR_HI;
      default:         fileVal = isGpr ? ramBus.rdata : (isExt ? extRd_ff : `TRC_BYTE_ZERO);
    endcase
  end

  assign ramBus.addr  = RA_W'(eff - GPR_BASE);
  assign ramBus.re    = (phase_ff == TRC_Q2) && isGpr;
  assign ramBus.we    = atQ4 && exe && toF && isGpr;
  assign ramBus.wdata = res;

  trc_gpr_ram #(
    .DEPTH (DATA_BYTES)
  ) u_gpr (
    .clk    (clk),
    .arst_n (arst_n),
    .bus    (ramBus.mem)
  );

  // ----------------------------------------------------------------------
  // alu and decode
  // ----------------------------------------------------------------------
  assign kLit    = ir_ff[`TRC_F_K8];
  assign bitMask = trc_byte_t'(1) << ir_ff[`TRC_F_BIT];
  assign addRes  = {1'b0, fileVal} + {1'b0, w_ff};
  assign subRes  = {1'b0, fileVal} + {1'b0, ~w_ff} + 9'h001;
  assign addNib  = {1'b0, fileVal[3:0]} + {1'b0, w_ff[3:0]};
  assign subNib  = {1'b0, fileVal[3:0]} + {1'b0, ~w_ff[3:0]} + 5'h01;

  always_comb begin
    res    = fileVal;
    toW    = !ir_ff[`TRC_F_DEST];
    toF    = ir_ff[`TRC_F_DEST];
    cAff   = 1'b0;
    dcAff  = 1'b0;
    zAff   = 1'b0;
    cNew   = status_ff[`TRC_ST_C];
    dcNew  = status_ff[`TRC_ST_DC];
    skip   = 1'b0;
    flow   = 1'b0;
    push   = 1'b0;
    pop    = 1'b0;
    ctrlOp = 1'b0;
    tgt    = `TRC_PCX_W'(kLit);
    casez (ir_ff)
      `TRC_OP_NOP: begin
        toW = 1'b0;
        toF = 1'b0;
      end
      `TRC_OP_CTRL: begin
        toW    = 1'b0;
        toF    = 1'b0;
        ctrlOp = 1'b1;
      end
      `TRC_OP_MOVWF: begin
        res = w_ff;
        toW = 1'b0;
        toF = 1'b1;
      end
      `TRC_OP_CLRW: begin
        res  = `TRC_BYTE_ZERO;
        toW  = 1'b1;
        toF  = 1'b0;
        zAff = 1'b1;
      end
      `TRC_OP_CLRF: begin
        res  = `TRC_BYTE_ZERO;
        toW  = 1'b0;
        toF  = 1'b1;
        zAff = 1'b1;
      end
      `TRC_OP_SUBWF: begin
        res   = subRes[7:0];
        cAff  = 1'b1;
        dcAff = 1'b1;
        zAff  = 1'b1;
        cNew  = subRes[8];
        dcNew = subNib[4];
      end
      `TRC_OP_ADDWF: begin
        res   = addRes[7:0];
        cAff  = 1'b1;
        dcAff = 1'b1;
        zAff  = 1'b1;
        cNew  = addRes[8];
        dcNew = addNib[4];
      end
      `TRC_OP_DECF:   begin res = fileVal - 8'h01; zAff = 1'b1; end
      `TRC_OP_IORWF:  begin res = fileVal | w_ff;  zAff = 1'b1; end
      `TRC_OP_ANDWF:  begin res = fileVal & w_ff;  zAff = 1'b1; end
      `TRC_OP_XORWF:  begin res = fileVal ^ w_ff;  zAff = 1'b1; end
      `TRC_OP_MOVF:   begin res = fileVal;         zAff = 1'b1; end
      `TRC_OP_COMF:   begin res = ~fileVal;        zAff = 1'b1; end
      `TRC_OP_INCF:   begin res = fileVal + 8'h01; zAff = 1'b1; end
      `TRC_OP_DECFSZ: begin
        res  = fileVal - 8'h01;
        skip = (res == `TRC_BYTE_ZERO);
      end
      `TRC_OP_INCFSZ: begin
        res  = fileVal + 8'h01;
        skip = (res == `TRC_BYTE_ZERO);
      end
      `TRC_OP_RRF: begin
        res  = {status_ff[`TRC_ST_C], fileVal[7:1]};
        cAff = 1'b1;
        cNew = fileVal[0];
      end
      `TRC_OP_RLF: begin
        res  = {fileVal[6:0], status_ff[`TRC_ST_C]};
        cAff = 1'b1;
        cNew = fileVal[7];
      end
      `TRC_OP_SWAPF: res = {fileVal[3:0], fileVal[7:4]};
      `TRC_OP_BCF: begin
        res = fileVal & ~bitMask;
        toW = 1'b0;
        toF = 1'b1;
      end
      `TRC_OP_BSF: begin
        res = fileVal | bitMask;
        toW = 1'b0;
        toF = 1'b1;
      end
      `TRC_OP_BTFSC: begin
        toW  = 1'b0;
        toF  = 1'b0;
        skip = ((fileVal & bitMask) == `TRC_BYTE_ZERO);
      end
      `TRC_OP_BTFSS: begin
        toW  = 1'b0;
        toF  = 1'b0;
        skip = ((fileVal & bitMask) != `TRC_BYTE_ZERO);
      end
      `TRC_OP_RETLW: begin
        res  = kLit;
        toW  = 1'b1;
        toF  = 1'b0;
        flow = 1'b1;
        pop  = 1'b1;
        tgt  = `TRC_PCX_W'(stk0_ff);
      end
      `TRC_OP_CALL: begin
        toW  = 1'b0;
        toF  = 1'b0;
        flow = 1'b1;
        push = 1'b1;
      end
      `TRC_OP_GOTO: begin
        toW  = 1'b0;
        toF  = 1'b0;
        flow = 1'b1;
        tgt  = `TRC_PCX_W'(ir_ff[`TRC_F_K9]);
      end
      `TRC_OP_MOVLW: begin res = kLit; toW = 1'b1; toF = 1'b0; end
      `TRC_OP_IORLW: begin res = w_ff | kLit; toW = 1'b1; toF = 1'b0; zAff = 1'b1; end
      `TRC_OP_ANDLW: begin res = w_ff & kLit; toW = 1'b1; toF = 1'b0; zAff = 1'b1; end
      `TRC_OP_XORLW: begin res = w_ff ^ kLit; toW = 1'b1; toF = 1'b0; zAff = 1'b1; end
      default: begin
        toW = 1'b0;
        toF = 1'b0;
      end
    endcase
    if (toF && (eff == `TRC_ADR_PCL)) begin
      flow = 1'b1;
      tgt  = `TRC_PCX_W'(res);
    end
  end

  // ----------------------------------------------------------------------
  // status flags
  // ----------------------------------------------------------------------
  always_comb begin
    nxt_status = status_ff;
    if (toF && (eff == `TRC_ADR_STATUS)) begin
      nxt_status = (status_ff & ~`TRC_ST_WMASK) | (res & `TRC_ST_WMASK);
    end
    if (zAff) begin
      nxt_status[`TRC_ST_Z] = (res == `TRC_BYTE_ZERO);
    end
    if (cAff) begin
      nxt_status[`TRC_ST_C] = cNew;
    end
    if (dcAff) begin
      nxt_status[`TRC_ST_DC] = dcNew;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      status_ff <= `TRC_ST_RESET;
      fsr_ff    <= `TRC_FSR_HI;
      w_ff      <= `TRC_BYTE_ZERO;
    end else if (atQ4 && exe) begin
      status_ff <= nxt_status;
      if (toF && (eff == `TRC_ADR_FSR)) begin
        fsr_ff <= res;
      end
      if (toW) begin
        w_ff <= res;
      end
    end
  end

  // ----------------------------------------------------------------------
  // fetch path and pipeline
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pc_ff       <= '1;
      progAddr_ff <= '0;
    end else if (phase_ff == TRC_Q1) begin
      progAddr_ff <= pc_ff;
      pc_ff       <= pc_ff + 1'b1;
    end else if (atQ4 && exe && flow) begin
      pc_ff <= tgt[PC_W-1:0];
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ir_ff       <= '0;
      exeValid_ff <= 1'b0;
    end else if (atQ4) begin
      ir_ff       <= progData;
      exeValid_ff <= !(exe && (flow || skip));
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      stk0_ff <= '0;
      stk1_ff <= '0;
    end else if (atQ4 && exe) begin
      if (push) begin
        stk0_ff <= progAddr_ff;
        stk1_ff <= stk0_ff;
      end else if (pop) begin
        stk0_ff <= stk1_ff;
      end
    end
  end

  // ----------------------------------------------------------------------
  // peripheral data bus and control strobes
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      periphAddr_ff   <= '0;
      periphRe_ff     <= 1'b0;
      periphWe_ff     <= 1'b0;
      periphWrData_ff <= `TRC_BYTE_ZERO;
      extRd_ff        <= `TRC_BYTE_ZERO;
      ctrlStrobe_ff   <= 1'b0;
      ctrlCode_ff     <= '0;
      ctrlData_ff     <= `TRC_BYTE_ZERO;
    end else begin
      periphRe_ff   <= (phase_ff == TRC_Q1) && isExt && exe;
      periphWe_ff   <= atQ4 && exe && toF && isExt;
      ctrlStrobe_ff <= atQ4 && exe && ctrlOp;
      if (phase_ff == TRC_Q1) begin
        periphAddr_ff <= eff;
      end
      if (phase_ff == TRC_Q2) begin
        extRd_ff <= periphRdData;
      end
      if (atQ4) begin
        periphWrData_ff <= res;
        ctrlCode_ff     <= ir_ff[`TRC_F_CTRL];
        ctrlData_ff     <= w_ff;
      end
    end
  end

  assign progAddr     = progAddr_ff;
  assign periphAddr   = periphAddr_ff;
  assign periphRe     = periphRe_ff;
  assign periphWe     = periphWe_ff;
  assign periphWrData = periphWrData_ff;
  assign ctrlStrobe   = ctrlStrobe_ff;
  assign ctrlCode     = ctrlCode_ff;
  assign ctrlData     = ctrlData_ff;
endmodule // trc_core

// file: testbench/trc_core_sva.sv
// port assertions for the tiny risc core datapath
`timescale 1ns/1ps
`include "trc_defines.svh"
module trc_core_sva #(
  parameter int  PROG_DEPTH = `TRC_PROG_DEPTH,
  parameter int  DATA_BYTES = `TRC_DATA_BYTES,
  localparam int PC_W       = $clog2(PROG_DEPTH)
) (
  input wire logic               clk,
  input wire logic               arst_n,
  input wire logic [PC_W-1:0]    progAddr,
  input wire trc_pkg::trc_fadr_t periphAddr,
  input wire logic               periphRe,
  input wire logic               periphWe,
  input wire logic               ctrlStrobe
);
  import trc_pkg::*;
  logic [1:0] phaseCnt_ff;

  // ----------------------------------------------------------------------
  // phase tracking: edge k after release ends phase ((k-1) mod 4)+1
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      phaseCnt_ff <= 2'h0;
    end else begin
      phaseCnt_ff <= phaseCnt_ff + 2'h1;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  AST_RE_PHASE: assert property (periphRe |-> phaseCnt_ff == 2'h1)
    else $error("operand read outside the second phase");
  AST_WE_PHASE: assert property (periphWe |-> phaseCnt_ff == 2'h0)
    else $error("destination write not after the fourth phase");
  AST_CTRL_PHASE: assert property (ctrlStrobe |-> phaseCnt_ff == 2'h0 ##1 !ctrlStrobe)
    else $error("control strobe misplaced or too long");
  AST_PC_PHASE: assert property ($changed(progAddr) |-> phaseCnt_ff == 2'h1)
    else $error("fetch address moved outside the first phase");
  AST_PC_HOLD: assert property ($changed(progAddr) |=> $stable(progAddr) [*3])
    else $error("fetch address not held for the instruction cycle");
  AST_RE_WE_GAP: assert property (periphRe |=> !periphWe [*2])
    else $error("write pulse too close after an operand read");
  AST_ADDR_HOLD: assert property (periphRe |=> $stable(periphAddr) [*2])
    else $error("operand address changed during execute");
  AST_EXT_MAP: assert property ((periphRe || periphWe) |->
    periphAddr inside {5'h01, 5'h05, 5'h06, 5'h07})
    else $error("external access to a core-held address");
endmodule // trc_core_sva

bind trc_core trc_core_sva #(.PROG_DEPTH(PROG_DEPTH), .DATA_BYTES(DATA_BYTES)) uCoreSva (
  .clk        (clk),
  .arst_n     (arst_n),
  .progAddr   (progAddr),
  .periphAddr (periphAddr),
  .periphRe   (periphRe),
  .periphWe   (periphWe),
  .ctrlStrobe (ctrlStrobe)
);

// file: testbench/trc_far_model.sv
// program store and external register model facing the core
`timescale 1ns/1ps
`include "trc_defines.svh"
module trc_far_model #(
  parameter int  PROG_DEPTH = `TRC_PROG_DEPTH,
  localparam int PC_W       = $clog2(PROG_DEPTH)
) (
  input wire logic               clk,
  input wire logic               arst_n,
  input wire logic [PC_W-1:0]    progAddr,
  output trc_pkg::trc_word_t     progData,
  input wire trc_pkg::trc_fadr_t periphAddr,
  input wire logic               periphRe,
  output trc_pkg::trc_byte_t     periphRdData,
  input wire logic               periphWe,
  input wire trc_pkg::trc_byte_t periphWrData,
  input wire logic               ctrlStrobe,
  input wire logic [2:0]         ctrlCode,
  input wire trc_pkg::trc_byte_t ctrlData
);
  import trc_pkg::*;
  trc_word_t   rom [PROG_DEPTH];
  trc_byte_t   regs [8];
  trc_byte_t   lastRd_ff;
  int          cyc;
  int          rdCnt;
  logic [15:0] wrLog [$];
  int          wrTime [$];
  logic [15:0] ctrlLog [$];

  // ----------------------------------------------------------------------
  // fetch, read answer, write and strobe logging
  // ----------------------------------------------------------------------
  assign progData = rom[progAddr];
  // bus shows the inverse of the last value when not read
  assign periphRdData = periphRe ? regs[periphAddr[2:0]] : ~lastRd_ff;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      lastRd_ff <= 8'h3c;
    end else begin
      lastRd_ff <= periphRdData;
    end
  end

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cyc   <= 0;
      rdCnt <= 0;
    end else begin
      cyc <= cyc + 1;
      if (periphRe) rdCnt <= rdCnt + 1;
      if (periphWe) begin
        regs[periphAddr[2:0]] <= periphWrData;
        wrLog.push_back({3'h0, periphAddr, periphWrData});
        wrTime.push_back(cyc);
      end
      if (ctrlStrobe) ctrlLog.push_back({5'h0, ctrlCode, ctrlData});
    end
  end
endmodule // trc_far_model

// file: testbench/tb_trc_core.sv
// self-checking bench for the tiny risc core datapath
`timescale 1ns/1ps
module tb_trc_core;
  import trc_pkg::*;
  localparam int PROG_DEPTH = 512;
  localparam int PC_W       = $clog2(PROG_DEPTH);
  logic       clk;
  logic       arst_n;
  logic [PC_W-1:0] progAddr;
  trc_word_t  progData;
  trc_fadr_t  periphAddr;
  logic       periphRe;
  logic       periphWe;
  trc_byte_t  periphRdData;
  trc_byte_t  periphWrData;
  logic       ctrlStrobe;
  logic [2:0] ctrlCode;
  trc_byte_t  ctrlData;
  int         error_cnt;
  int         tests_run;
  int         tmo;

  trc_core #(.PROG_DEPTH(PROG_DEPTH), .DATA_BYTES(24)) DUT (
    .clk(clk), .arst_n(arst_n), .progAddr(progAddr), .progData(progData),
    .periphAddr(periphAddr), .periphRe(periphRe), .periphRdData(periphRdData),
    .periphWe(periphWe), .periphWrData(periphWrData), .ctrlStrobe(ctrlStrobe),
    .ctrlCode(ctrlCode), .ctrlData(ctrlData));

  trc_far_model #(.PROG_DEPTH(PROG_DEPTH)) uFar (
    .clk(clk), .arst_n(arst_n), .progAddr(progAddr), .progData(progData),
    .periphAddr(periphAddr), .periphRe(periphRe), .periphRdData(periphRdData),
    .periphWe(periphWe), .periphWrData(periphWrData), .ctrlStrobe(ctrlStrobe),
    .ctrlCode(ctrlCode), .ctrlData(ctrlData));

  // ----------------------------------------------------------------------
  // clock, timeout and shared tasks
  // ----------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  always @(posedge clk) begin
    tmo++;
    if (tmo == 5000) begin
      error_cnt++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chkVal(input string what, input logic [15:0] expV, input logic [15:0] gotV);
    tests_run++;
    if (gotV !== expV) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", what, expV, gotV);
    end
  endtask

  // resets the core with a fresh program and checks the first fetch
  task automatic restart(input trc_word_t prog[$]);
    @(posedge clk);
    arst_n <= 1'b0;
    for (int i = 0; i < PROG_DEPTH; i++) uFar.rom[i] = (i < prog.size()) ? prog[i] : 12'h000;
    uFar.regs[6] = 8'ha5;
    uFar.wrLog.delete();
    uFar.wrTime.delete();
    uFar.ctrlLog.delete();
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    #1 chkVal("first fetch", 16'(PROG_DEPTH - 1), 16'(progAddr));
  endtask

  task automatic chkWrites(input logic [15:0] expW[$]);
    chkVal("write count", 16'(expW.size()), 16'(uFar.wrLog.size()));
    foreach (expW[i]) chkVal("write", expW[i], (i < uFar.wrLog.size()) ? uFar.wrLog[i] : 16'hxxxx);
  endtask

  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  task automatic testAlu();
    restart('{12'hc3c, 12'h028, 12'hcc5, 12'h1c8, 12'h025, 12'h203, 12'h025, 12'hc05,
              12'h028, 12'hc06, 12'h088, 12'h025, 12'h203, 12'h025, 12'hc05, 12'h088,
              12'h203, 12'h025, 12'hc81, 12'h028, 12'h308, 12'h025, 12'hc0f, 12'hfff,
              12'he3c, 12'hd01, 12'h025, 12'ha1b});
    repeat (4 * 34) @(posedge clk);
    chkWrites('{16'h0501, 16'h051b, 16'h05ff, 16'h0518,
                16'h051f, 16'h05c0, 16'h0531});
    $display("test alu done");
  endtask

  task automatic testRegs();
    restart('{12'hc10, 12'h024, 12'h204, 12'h025, 12'hc5a, 12'h020, 12'h210, 12'h025,
              12'h206, 12'h027, 12'hc0e, 12'h022, 12'h025, 12'h025, 12'hc77, 12'h025,
              12'ha10});
    repeat (4 * 22) @(posedge clk);
    chkWrites('{16'h05f0, 16'h055a, 16'h07a5, 16'h0577});
    chkVal("external reads", 16'd5, 16'(uFar.rdCnt));
    $display("test registers done");
  endtask

  task automatic testFlow();
    restart('{12'hc33, 12'h025, 12'h025, 12'ha05, 12'h025, 12'h025, 12'h001, 12'h002,
              12'h003, 12'h004, 12'h005, 12'h006, 12'h007, 12'ha0d});
    repeat (4 * 20) @(posedge clk);
    chkWrites('{16'h0533, 16'h0533, 16'h0533});
    if (uFar.wrTime.size() == 3) begin
      chkVal("single cycle gap", 16'd4, 16'(uFar.wrTime[1] - uFar.wrTime[0]));
      chkVal("branch gap", 16'd12, 16'(uFar.wrTime[2] - uFar.wrTime[1]));
    end
    chkVal("strobe count", 16'd7, 16'(uFar.ctrlLog.size()));
    foreach (uFar.ctrlLog[i]) chkVal("strobe", {5'h0, 3'(i + 1), 8'h33}, uFar.ctrlLog[i]);
    $display("test flow done");
  endtask

  task automatic testMisc();
    restart('{12'hc96, 12'h028, 12'h388, 12'h025, 12'h348, 12'h025, 12'h268, 12'h0e8,
              12'h188, 12'h025, 12'h040, 12'h108, 12'h025, 12'h068, 12'h2e8, 12'h3e8,
              12'h025, 12'h508, 12'h628, 12'h025, 12'h708, 12'h025, 12'h919, 12'h025,
              12'ha18, 12'h8a7});
    repeat (4 * 34) @(posedge clk);
    chkWrites('{16'h0569, 16'h052c, 16'h0544, 16'h0568, 16'h05a7});
    $display("test misc done");
  endtask

  initial begin
    arst_n    = 1'b0;
    error_cnt = 0;
    tests_run = 0;
    tmo       = 0;
    testAlu();
    testRegs();
    testFlow();
    testMisc();
    give_verdict();
  end
endmodule // tb_trc_core
